// ---- core/bch_codec.sv ----
// Purpose: bch(15,7) encoder and majority logic decoder, bit serial
// Assumes: requests come from logic on clk_i, so no synchronisers
// Notes:   serial order on both sides is code word bit 14 first (m6)

// ------------------------------------------------------------
// codec top
// ------------------------------------------------------------
module bch_codec (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // encoder side
    input wire bch_pkg::bch_enc_req_type enc_req_i,
    output bch_pkg::bch_enc_rsp_type enc_rsp_o,
    // decoder side
    input wire bch_pkg::bch_dec_req_type dec_req_i,
    output bch_pkg::bch_dec_rsp_type dec_rsp_o
);
    import bch_pkg::*;

    // ------------------------------------------------------------
    // encoder control
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ENC_IDLE,
        ENC_CALC,
        ENC_SEND
    } bch_enc_state_type;

    bch_enc_state_type enc_state_r;
    bch_enc_state_type enc_state_nxt;
    logic [6:0] enc_data_r;
    logic enc_par_sel_r;
    logic [14:0] enc_tx_r;
    logic [BCH_CNT_W-1:0] enc_cnt_r;
    bch_enc_rsp_type enc_rsp_r;

    wire enc_idle = (enc_state_r == ENC_IDLE);
    wire enc_take = enc_idle && enc_req_i.start;
    wire enc_send_last = (enc_cnt_r == BCH_LAST_BIT);
    wire lfsr_done;
    wire [7:0] lfsr_parity;
    wire [14:0] par_word;
    // serial result laid out as data times x^8 over the parity
    wire [14:0] lfsr_word = {enc_data_r, lfsr_parity};
    wire [14:0] enc_word = enc_par_sel_r ? par_word : lfsr_word;

    // the serial generator runs on every block; the matrix path only
    // replaces its result, so both can be cross-checked from outside
    bch_lfsr_enc u_lfsr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(enc_take),
        .data_i(enc_req_i.data),
        .busy_o(),
        .done_o(lfsr_done),
        .parity_o(lfsr_parity)
    );

    bch_par_enc u_par (
        .data_i(enc_data_r),
        .word_o(par_word)
    );

    always_comb begin
        enc_state_nxt = enc_state_r;
        case (enc_state_r)
            ENC_IDLE: begin
                if (enc_req_i.start) begin
                    enc_state_nxt = ENC_CALC;
                end
            end
            ENC_CALC: begin
                if (lfsr_done) begin
                    enc_state_nxt = ENC_SEND;
                end
            end
            ENC_SEND: begin
                if (enc_send_last) begin
                    enc_state_nxt = ENC_IDLE;
                end
            end
            default: begin
                enc_state_nxt = ENC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enc_state_r <= ENC_IDLE;
            enc_cnt_r <= '0;
            enc_data_r <= 7'h00;
            enc_par_sel_r <= 1'b0;
            enc_tx_r <= 15'h0000;
        end else begin
            enc_state_r <= enc_state_nxt;
            if (enc_take) begin
                enc_data_r <= enc_req_i.data;
                enc_par_sel_r <= enc_req_i.par_sel;
            end
            if (enc_state_r == ENC_CALC && lfsr_done) begin
                enc_tx_r <= enc_word;
                enc_cnt_r <= '0;
            end else if (enc_state_r == ENC_SEND) begin
                // bit 14 (m6) leaves first
                enc_tx_r <= {enc_tx_r[13:0], 1'b0};
                enc_cnt_r <= enc_cnt_r + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // encoder outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enc_rsp_r <= '0;
        end else begin
            enc_rsp_r.done <= 1'b0;
            enc_rsp_r.bit_vld <= 1'b0;
            if (enc_take) begin
                enc_rsp_r.busy <= 1'b1;
            end
            if (enc_state_r == ENC_CALC && lfsr_done) begin
                enc_rsp_r.word <= enc_word;
            end
            if (enc_state_r == ENC_SEND) begin
                enc_rsp_r.bit_val <= enc_tx_r[14];
                enc_rsp_r.bit_vld <= 1'b1;
                if (enc_send_last) begin
                    enc_rsp_r.busy <= 1'b0;
                    enc_rsp_r.done <= 1'b1;
                end
            end
        end
    end

    assign enc_rsp_o = enc_rsp_r;

    // ------------------------------------------------------------
    // decoder datapath
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DEC_IDLE,
        DEC_LOAD,
        DEC_FIX
    } bch_dec_state_type;

    bch_dec_state_type dec_state_r;
    bch_dec_state_type dec_state_nxt;
    logic [14:0] dec_sr_r;
    logic [14:0] dec_out_r;
    logic [BCH_CNT_W-1:0] dec_cnt_r;
    bch_dec_rsp_type dec_rsp_r;
    logic [BCH_NCHK-1:0] chk_sum;
    logic [2:0] chk_cnt [0:BCH_NCHK];

    // four sums, each orthogonal on the last register bit
    assign chk_cnt[0] = 3'h0;
    genvar gc;
    generate
        for (gc = 0; gc < BCH_NCHK; gc++) begin : g_chk
            assign chk_sum[gc] = ^(dec_sr_r & BCH_CHK_MASK[gc]);
            assign chk_cnt[gc+1] = chk_cnt[gc] + {2'b00, chk_sum[gc]};
        end
    endgenerate

    // two errors can fool at most two sums, so a clear majority decides
    wire maj = (chk_cnt[BCH_NCHK] >= BCH_MAJ_MIN);
    wire fixed_bit = dec_sr_r[14] ^ maj;
    wire dec_in_load = (dec_state_r == DEC_LOAD);
    wire dec_in_fix = (dec_state_r == DEC_FIX);
    wire dec_load_en = dec_in_load && dec_req_i.bit_vld;
    // input path during load, correction feedback afterwards
    wire dec_feed = dec_in_load ? dec_req_i.bit_val : fixed_bit;
    wire dec_shift = dec_load_en || dec_in_fix;
    wire dec_cnt_last = (dec_cnt_r == BCH_LAST_BIT);
    wire dec_take = (dec_state_r == DEC_IDLE) && dec_req_i.start;

    always_comb begin
        dec_state_nxt = dec_state_r;
        case (dec_state_r)
            DEC_IDLE: begin
                if (dec_req_i.start) begin
                    dec_state_nxt = DEC_LOAD;
                end
            end
            DEC_LOAD: begin
                if (dec_req_i.bit_vld && dec_cnt_last) begin
                    dec_state_nxt = DEC_FIX;
                end
            end
            DEC_FIX: begin
                if (dec_cnt_last) begin
                    dec_state_nxt = DEC_IDLE;
                end
            end
            default: begin
                dec_state_nxt = DEC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_state_r <= DEC_IDLE;
            dec_sr_r <= 15'h0000;
            dec_out_r <= 15'h0000;
            dec_cnt_r <= '0;
        end else begin
            dec_state_r <= dec_state_nxt;
            if (dec_take) begin
                dec_cnt_r <= '0;
            end else if (dec_shift) begin
                // right shift toward bit 14, count wraps into the fix phase
                dec_sr_r <= {dec_sr_r[13:0], dec_feed};
                dec_cnt_r <= dec_cnt_last ? '0 : dec_cnt_r + 4'h1;
            end
            if (dec_in_fix) begin
                dec_out_r <= {dec_out_r[13:0], fixed_bit};
            end
        end
    end

    // ------------------------------------------------------------
    // decoder outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_rsp_r <= '0;
        end else begin
            dec_rsp_r.done <= 1'b0;
            dec_rsp_r.bit_vld <= 1'b0;
            if (dec_take) begin
                dec_rsp_r.busy <= 1'b1;
            end
            if (dec_in_fix) begin
                dec_rsp_r.bit_val <= fixed_bit;
                dec_rsp_r.bit_vld <= 1'b1;
                if (dec_cnt_last) begin
                    dec_rsp_r.busy <= 1'b0;
                    dec_rsp_r.done <= 1'b1;
                    dec_rsp_r.word <= {dec_out_r[13:0], fixed_bit};
                    dec_rsp_r.data <= dec_out_r[13:7];
                end
            end
        end
    end

    assign dec_rsp_o = dec_rsp_r;

endmodule // bch_codec

// ---- core/bch_pkg.sv ----
// Purpose: shared constants and carrier types for the bch codec
// Assumes: code word bit i is the coefficient of x^i
// Notes:   information bit m_i sits at code word bit 8+i

package bch_pkg;

    // ------------------------------------------------------------
    // code geometry
    // ------------------------------------------------------------
    localparam int BCH_N = 15;
    localparam int BCH_K = 7;
    localparam int BCH_NPAR = 8;
    localparam int BCH_ENC_ROUNDS = 7;
    localparam int BCH_NCHK = 4;
    localparam int BCH_CNT_W = 4;
    localparam logic [BCH_CNT_W-1:0] BCH_LAST_BIT = 4'he;
    localparam logic [2:0] BCH_MAJ_MIN = 3'h3;

    // 1 + x^4 + x^6 + x^7 + x^8, bit i is the x^i coefficient
    localparam logic [8:0] BCH_GEN_POLY = 9'h1d1;

    // generator matrix rows, parity in bits 0..7, identity in 8..14
    localparam logic [14:0] BCH_GEN_ROW [0:6] = '{
        15'h01d1, 15'h0273, 15'h04e6, 15'h081d,
        15'h103a, 15'h2074, 15'h40e8
    };

    // check sums orthogonal on bit 14, built from parity check rows
    localparam logic [14:0] BCH_CHK_MASK [0:3] = '{
        15'h5808, 15'h4580, 15'h6022, 15'h4045
    };

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic par_sel;
        logic [6:0] data;
    } bch_enc_req_type;

    typedef struct packed {
        logic busy;
        logic done;
        logic bit_val;
        logic bit_vld;
        logic [14:0] word;
    } bch_enc_rsp_type;

    typedef struct packed {
        logic start;
        logic bit_val;
        logic bit_vld;
    } bch_dec_req_type;

    typedef struct packed {
        logic busy;
        logic done;
        logic bit_val;
        logic bit_vld;
        logic [14:0] word;
        logic [6:0] data;
    } bch_dec_rsp_type;

endpackage

// ---- core/bch_lfsr_enc.sv ----
// Purpose: serial feedback shift register parity generator
// Assumes: start_i is a one-cycle pulse while the block is idle
// Notes:   seven rounds, parity ready on the done pulse

module bch_lfsr_enc (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request
    input wire logic start_i,
    input wire logic [6:0] data_i,
    // result
    output logic busy_o,
    output logic done_o,
    output logic [7:0] parity_o
);
    import bch_pkg::*;

    logic [14:0] sr_r;
    logic [14:0] sr_nxt;
    logic [2:0] cnt_r;
    logic busy_r;
    logic done_r;
    wire fb = sr_r[6] ^ sr_r[14];
    wire last_round = (cnt_r == 3'(BCH_ENC_ROUNDS - 1));

    // ------------------------------------------------------------
    // one round: shift right, feed back, modulo-2 sum
    // ------------------------------------------------------------
    assign sr_nxt[0] = 1'b0;
    assign sr_nxt[7] = fb & BCH_GEN_POLY[0];
    genvar gi;
    generate
        for (gi = 1; gi < 7; gi++) begin : g_msg
            assign sr_nxt[gi] = sr_r[gi-1];
        end
        for (gi = 1; gi < 8; gi++) begin : g_tap
            assign sr_nxt[7+gi] = sr_r[6+gi] ^ (fb & BCH_GEN_POLY[gi]);
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sr_r <= 15'h0000;
            cnt_r <= 3'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start_i && !busy_r) begin
                // message in 0..6 with m6 nearest the taps, zeros for parity
                sr_r <= {8'h00, data_i};
                cnt_r <= 3'h0;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                sr_r <= sr_nxt;
                cnt_r <= cnt_r + 3'h1;
                if (last_round) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end

    assign busy_o = busy_r;
    assign done_o = done_r;
    assign parity_o = sr_r[14:7];

endmodule // bch_lfsr_enc

// ---- core/bch_par_enc.sv ----
// Purpose: parallel generator matrix encoder
// Assumes: data_i bit i is information bit m_i
// Notes:   purely combinational, one gated xor stage per row, chained over the seven rows

module bch_par_enc (
    // information word
    input wire logic [6:0] data_i,
    // code word
    output logic [14:0] word_o
);
    import bch_pkg::*;

    logic [14:0] acc [0:7];

    assign acc[0] = 15'h0000;
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_row
            assign acc[gi+1] = acc[gi] ^ (data_i[gi] ? BCH_GEN_ROW[gi]
                                                      : 15'h0000);
        end
    endgenerate

    assign word_o = acc[7];

endmodule // bch_par_enc

// ---- testbench/bch_codec_asserts.sv ----
// Purpose: port level checks on the codec
// Assumes: one clock, sync reset
// Notes:   cycle figures follow the hand-over timing
module bch_codec_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // encoder side
    input wire bch_pkg::bch_enc_req_type enc_req_i,
    input wire bch_pkg::bch_enc_rsp_type enc_rsp_o,
    // decoder side
    input wire bch_pkg::bch_dec_req_type dec_req_i,
    input wire bch_pkg::bch_dec_rsp_type dec_rsp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import bch_pkg::*;
    // --------
    // helpers
    // --------
    wire logic enc_take = enc_req_i.start && !enc_rsp_o.busy;
    wire logic dec_take = dec_req_i.start && !dec_rsp_o.busy;
    logic [4:0] enc_run_r;
    logic [3:0] dec_cnt_r;
    logic dec_load_r;
    wire logic dec_last = dec_load_r && dec_req_i.bit_vld && dec_cnt_r == 4'he;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enc_run_r <= 5'h00;
            dec_cnt_r <= 4'h0;
            dec_load_r <= 1'b0;
        end else begin
            enc_run_r <= enc_rsp_o.bit_vld ? enc_run_r + 5'h01 : 5'h00;
            if (dec_take) begin
                dec_load_r <= 1'b1;
                dec_cnt_r <= 4'h0;
            end else if (dec_last) begin
                dec_load_r <= 1'b0;
            end else if (dec_load_r && dec_req_i.bit_vld) begin
                dec_cnt_r <= dec_cnt_r + 4'h1;
            end
        end
    end
    // --------
    // checks
    // --------
    enc_busy_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        enc_take |=> enc_rsp_o.busy [*8]) else $error("encoder busy not held");
    enc_first_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        enc_take |-> ##9 !enc_rsp_o.bit_vld ##1
        (enc_rsp_o.bit_vld && enc_rsp_o.bit_val == enc_rsp_o.word[14]))
        else $error("encoder first bit wrong");
    enc_done_lat_a: assert property (@(posedge clk_i) disable iff (rst_i)
        enc_take |-> ##24 (enc_rsp_o.done && !enc_rsp_o.busy))
        else $error("encoder done late");
    enc_burst_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        enc_rsp_o.done |-> enc_run_r == 5'h0e && enc_rsp_o.bit_vld)
        else $error("encoder burst not 15 bits");
    dec_busy_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dec_take |=> dec_rsp_o.busy) else $error("decoder busy missing");
    dec_answer_lat_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dec_last |-> ##1 !dec_rsp_o.bit_vld ##1 dec_rsp_o.bit_vld ##14
        (dec_rsp_o.done && dec_rsp_o.bit_vld)) else $error("decoder timing");
    dec_data_sys_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dec_rsp_o.done |-> dec_rsp_o.data == dec_rsp_o.word[14:8])
        else $error("decoder data not systematic");
    reset_quiet_a: assert property (@(posedge clk_i)
        rst_i |=> enc_rsp_o == '0 && dec_rsp_o == '0)
        else $error("outputs not cleared by reset");
    enc_take_c: cover property (@(posedge clk_i) enc_take);
    enc_refuse_c: cover property (@(posedge clk_i)
        enc_req_i.start && enc_rsp_o.busy);
    dec_last_c: cover property (@(posedge clk_i) dec_last);
endmodule // bch_codec_chk

bind bch_codec bch_codec_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .enc_req_i(enc_req_i), .enc_rsp_o(enc_rsp_o),
    .dec_req_i(dec_req_i), .dec_rsp_o(dec_rsp_o));

// ---- testbench/bch_link_model.sv ----
// Purpose: far side: frame source for decoder, sink for both streams
// Assumes: go_i pulsed only while the decoder is idle
// Notes:   data line shows the inverse of its last bit between bits
module bch_link_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // command
    input wire logic go_i,
    input wire logic gap_i,
    input wire logic [14:0] word_i,
    // codec outputs
    input wire bch_pkg::bch_enc_rsp_type enc_rsp_i,
    input wire bch_pkg::bch_dec_rsp_type dec_rsp_i,
    // frame out and captures
    output bch_pkg::bch_dec_req_type dec_req_o = '0,
    output logic [14:0] enc_cap_o,
    output logic [14:0] dec_cap_o,
    output logic [4:0] dec_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import bch_pkg::*;
    logic [14:0] sh_r;
    logic [3:0] left_r;
    always @(posedge clk_i) begin
        dec_req_o.start <= 1'b0;
        if (enc_rsp_i.bit_vld) begin
            enc_cap_o <= {enc_cap_o[13:0], enc_rsp_i.bit_val};
        end
        if (dec_rsp_i.bit_vld) begin
            dec_cap_o <= {dec_cap_o[13:0], dec_rsp_i.bit_val};
            dec_cnt_o <= dec_cnt_o + 5'h01;
        end
        if (rst_i) begin
            dec_req_o <= '0;
            left_r <= 4'h0;
        end else if (go_i) begin
            dec_req_o.start <= 1'b1;
            dec_req_o.bit_vld <= 1'b0;
            sh_r <= word_i;
            left_r <= 4'hf;
            dec_cnt_o <= 5'h00;
        end else if (left_r != 4'h0 && !(gap_i && dec_req_o.bit_vld)) begin
            dec_req_o.bit_vld <= 1'b1;
            dec_req_o.bit_val <= sh_r[14];
            sh_r <= {sh_r[13:0], 1'b0};
            left_r <= left_r - 4'h1;
        end else begin
            dec_req_o.bit_vld <= 1'b0;
            dec_req_o.bit_val <= ~dec_req_o.bit_val;
        end
    end
endmodule // bch_link_model

// ---- testbench/bch15_7_codec_tb_top.sv ----
// Purpose: self-checking bench for the codec
// Assumes: far side stands in bch_link_model
// Notes:   outputs sampled on the falling edge
module bch15_7_codec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bch_pkg::*;
    logic clk_i;
    logic rst_i;
    logic go;
    logic gap;
    logic [14:0] tx_word;
    logic [14:0] enc_cap;
    logic [14:0] dec_cap;
    logic [4:0] dec_cnt;
    bch_enc_req_type enc_req;
    bch_enc_rsp_type enc_rsp;
    bch_dec_req_type dec_req;
    bch_dec_rsp_type dec_rsp;
    int n_fail;
    int total_checks;
    bch_codec uut (.clk_i(clk_i), .rst_i(rst_i), .enc_req_i(enc_req),
        .enc_rsp_o(enc_rsp), .dec_req_i(dec_req), .dec_rsp_o(dec_rsp));
    bch_link_model u_link (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .gap_i(gap), .word_i(tx_word), .enc_rsp_i(enc_rsp),
        .dec_rsp_i(dec_rsp), .dec_req_o(dec_req), .enc_cap_o(enc_cap),
        .dec_cap_o(dec_cap), .dec_cnt_o(dec_cnt));
    // --------
    // helpers
    // --------
    function automatic logic [14:0] ref_word(input logic [6:0] d);
        logic [14:0] r;
        r = {d, 8'h00};
        for (int i = 14; i >= 8; i--) begin
            if (r[i]) r ^= 15'(9'h1d1) << (i - 8);
        end
        // division clears the data places, so put the data back on top
        return {d, r[7:0]};
    endfunction
    task automatic chk(input string nm, input logic [14:0] seen,
        input logic [14:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic enc_start(input logic [6:0] d, input logic s);
        @(posedge clk_i);
        enc_req <= '{start: 1'b1, par_sel: s, data: d};
        @(posedge clk_i);
        enc_req.start <= 1'b0;
    endtask
    task automatic enc_wait(input logic [14:0] e);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (enc_rsp.done !== 1'b1 && n < 40);
        chk("enc_lat", 15'(n), 15'h0018);
        chk("enc_word", enc_rsp.word, e);
        // last bit stands with done, the model takes it one edge later
        @(negedge clk_i);
        chk("enc_serial", enc_cap, e);
    endtask
    task automatic dec_one(input logic [14:0] w, input logic [14:0] m,
        input logic g);
        int n;
        @(posedge clk_i);
        go <= 1'b1;
        tx_word <= w ^ m;
        gap <= g;
        @(posedge clk_i);
        go <= 1'b0;
        n = 1;
        do begin
            @(negedge clk_i);
            n++;
        end while (dec_rsp.done !== 1'b1 && n < 80);
        chk("dec_lat", 15'(n), g ? 15'h002f : 15'h0021);
        chk("dec_word", dec_rsp.word, w);
        chk("dec_data", 15'(dec_rsp.data), 15'(w[14:8]));
        @(negedge clk_i);
        chk("dec_serial", dec_cap, w);
        chk("dec_count", 15'(dec_cnt), 15'h000f);
    endtask
    // --------
    // scenarios
    // --------
    task automatic t_enc_table();
        logic [6:0] d [6] = '{7'h21, 7'h5b, 7'h00, 7'h7f, 7'h01, 7'h40};
        for (int i = 0; i < 12; i++) begin
            enc_start(d[i/2], i[0]);
            enc_wait(i < 2 ? 15'h21a5 : i < 4 ? 15'h5b6d : ref_word(d[i/2]));
        end
    endtask
    task automatic t_enc_b2b();
        enc_start(7'h21, 1'b0);
        repeat (4) @(posedge clk_i);
        enc_req <= '{start: 1'b1, par_sel: 1'b1, data: 7'h7f};
        @(posedge clk_i);
        enc_req.start <= 1'b0;
        repeat (18) @(posedge clk_i);
        enc_req <= '{start: 1'b1, par_sel: 1'b1, data: 7'h5b};
        @(negedge clk_i);
        chk("enc_done", 15'(enc_rsp.done), 15'h0001);
        chk("enc_keep", enc_rsp.word, 15'h21a5);
        @(posedge clk_i);
        enc_req.start <= 1'b0;
        enc_wait(15'h5b6d);
    endtask
    task automatic t_dec_sweep();
        dec_one(ref_word(7'h7f), 15'h0000, 1'b1);
        for (int i = 0; i < 15; i++) begin
            dec_one(15'h21a5, 15'h0001 << i, 1'b0);
            for (int j = i + 1; j < 15; j++) begin
                dec_one(15'h5b6d, (15'h0001 << i) | (15'h0001 << j), 1'(j - i));
            end
        end
    endtask
    task automatic t_mid_reset();
        logic seen;
        seen = 1'b0;
        enc_start(7'h7f, 1'b0);
        go <= 1'b1;
        tx_word <= 15'h5b6d;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("rst_enc", 15'(enc_rsp === '0), 15'h0001);
        chk("rst_dec", 15'(dec_rsp === '0), 15'h0001);
        repeat (40) begin
            @(negedge clk_i);
            seen = seen | enc_rsp.done | dec_rsp.done;
        end
        chk("rst_done", 15'(seen), 15'h0000);
        enc_start(7'h01, 1'b1);
        enc_wait(15'h01d1);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end
    initial begin
        rst_i = 1'b1;
        go = 1'b0;
        gap = 1'b0;
        tx_word = 15'h0000;
        enc_req = '0;
        n_fail = 0;
        total_checks = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("rst_val", 15'(enc_rsp === '0 && dec_rsp === '0), 15'h0001);
        t_enc_table();
        t_enc_b2b();
        t_dec_sweep();
        t_mid_reset();
        end_of_test();
    end
endmodule // bch15_7_codec_tb_top
